// ---- rtl/tcc_top.sv ----
// Behaviour
// (RULE1) sixteen-bit counter stepped by programmable prescaler
// (RULE2) eight channels, each capture or compare
// (RULE3) enabled compare action forces pin to output
// (RULE4) port writes go to latch when pin busy
// (RULE5) direction bit: zero capture, one compare
// (RULE6) force register always reads zero
// (RULE7) force bit does compare action, no flag
// (RULE8) mask bit makes compare pin an output
// (RULE9) channel 7 match copies masked data bits
// (RULE10) channel 7 data wins simultaneous lower match
// (RULE11) counter writable only in special mode
// (RULE12) counter read as one whole word
// (RULE13) counter write not aligned to prescaler
// (RULE14) enable clear stops counter and divide-by-64
// (RULE15) stop-in-wait halts timer during wait
// (RULE16) stop-in-debug halts timer during debug
// (RULE17) fast clear off: write one clears flag
// (RULE18) fast clear on: channel access clears flag
// (RULE19) fast clear on: counter access clears overflow
// (RULE20) action pairs: off, toggle, clear, set
// (RULE21) control registers reset to zero
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.svh"

module tcc_top
  import tcc_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned N_CH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic special_mode_i,
  input wire logic wait_mode_i,
  input wire logic debug_mode_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic pa_tick_o
);

  generate
    if (CNT_W != 16 || N_CH != 8) begin : g_bad_param
      $error("tcc_top supports only a 16-bit counter and 8 channels");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] tcc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    tcc_merge = r;
  endfunction

  // {valid, index} for the channel register block
  function automatic logic [3:0] tcc_chan_dec(input logic [7:0] adr);
    tcc_chan_dec = {(adr[7:5] == `TCC_CH_BLOCK) && (adr[1:0] == 2'h0), adr[4:2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state and bus decode

  tcc_state_type q;
  tcc_state_type d;

  logic req;
  logic wr;
  logic rd;
  logic [3:0] ch_dec;
  logic ch_acc;
  logic [2:0] ch_idx;
  logic cnt_acc;
  logic run;
  logic step;
  logic e64;
  logic [15:0] cnt_inc;
  logic [7:0] hit;
  logic [7:0] edge_ev;
  logic [7:0] force_w;
  logic [7:0] lvl_next;
  logic [7:0] own;
  logic [7:0] clr_ch;
  logic clr_ovf;
  logic cnt_written;
  logic ovf_set;

  assign req = wb_cyc_i & wb_stb_i & (q.bus == TCC_BUS_IDLE);
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign ch_dec = tcc_chan_dec(wb_adr_i);
  assign ch_acc = ch_dec[3];
  assign ch_idx = ch_dec[2:0];
  assign cnt_acc = req & (wb_adr_i == `TCC_OFF_COUNT);
  // decoded outside the next-state process so the pin logic sees no feedback loop
  assign cnt_written = wr & (wb_adr_i == `TCC_OFF_COUNT) & special_mode_i; // RULE11 RULE13
  assign force_w = (wr && wb_adr_i == `TCC_OFF_FORCE) ? (wb_dat_i[7:0] & {8{wb_sel_i[0]}}) : 8'h00; // RULE7

  // timer halts when disabled, or in wait/debug with the matching stop bit
  assign run = q.sc.en & ~(q.sc.stop_wait & wait_mode_i) & ~(q.sc.stop_dbg & debug_mode_i); // RULE14 RULE15 RULE16
  assign cnt_inc = q.cnt + 16'h0001;
  assign ovf_set = step & (q.cnt == `TCC_CNT_MAX) & ~cnt_written;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and pin action

  tcc_prescaler u_psc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .sel_i(q.psel),
    .step_o(step),
    .e64_o(e64)
  );

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_cmp
      assign hit[n] = step & q.pc.ios[n] & (q.chan[n] == cnt_inc) & ~cnt_written; // RULE2 RULE5
      assign edge_ev[n] = run & ~q.pc.ios[n] & (pin_i[n] ^ q.pin_prev[n]); // RULE5
    end
  endgenerate

  tcc_pin_logic u_pin (
    .ctl_i(q.pc),
    .hit_i(hit),
    .force_i(force_w),
    .lvl_i(q.lvl),
    .lvl_o(lvl_next),
    .own_o(own)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    clr_ch = 8'h00;
    clr_ovf = 1'b0;
    d.bus = req ? TCC_BUS_ACK : TCC_BUS_IDLE;
    d.pin_prev = pin_i;

    if (wr) begin
      if (wb_adr_i == `TCC_OFF_DIR) begin
        d.pc.ios = 8'(tcc_merge({24'h0, q.pc.ios}, wb_dat_i, wb_sel_i)); // RULE5
      end else if (wb_adr_i == `TCC_OFF_FORCE) begin
        // strobe only, no storage; see force_w
      end else if (wb_adr_i == `TCC_OFF_MASK7) begin
        d.pc.mask = 8'(tcc_merge({24'h0, q.pc.mask}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `TCC_OFF_DATA7) begin
        d.pc.data = 8'(tcc_merge({24'h0, q.pc.data}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `TCC_OFF_COUNT) begin
        // ignored outside special mode; prescaler phase is left alone
        if (special_mode_i) begin
          d.cnt = 16'(tcc_merge({16'h0, q.cnt}, wb_dat_i, wb_sel_i)); // RULE11 RULE13
        end
      end else if (wb_adr_i == `TCC_OFF_SYSCTL) begin
        if (wb_sel_i[0]) begin
          d.sc.en = wb_dat_i[`TCC_SC_EN_BIT];
          d.sc.stop_wait = wb_dat_i[`TCC_SC_WAIT_BIT];
          d.sc.stop_dbg = wb_dat_i[`TCC_SC_DBG_BIT];
          d.sc.fast_clr = wb_dat_i[`TCC_SC_FFC_BIT];
        end
      end else if (wb_adr_i == `TCC_OFF_ACTION) begin
        d.pc.act = 16'(tcc_merge({16'h0, q.pc.act}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `TCC_OFF_FLAGS) begin
        clr_ch = wb_dat_i[7:0] & {8{wb_sel_i[0]}}; // RULE17
        clr_ovf = wb_dat_i[`TCC_FLAG_OVF_BIT] & wb_sel_i[1];
      end else if (wb_adr_i == `TCC_OFF_PORTDIR) begin
        d.ddr = 8'(tcc_merge({24'h0, q.ddr}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `TCC_OFF_PORTDAT) begin
        // always lands in the latch; reaches the pin only when free
        d.port = 8'(tcc_merge({24'h0, q.port}, wb_dat_i, wb_sel_i)); // RULE4
      end else if (wb_adr_i == `TCC_OFF_PSEL) begin
        d.psel = 3'(tcc_merge({29'h0, q.psel}, wb_dat_i, wb_sel_i));
      end else if (ch_acc) begin
        d.chan[ch_idx] = 16'(tcc_merge({16'h0, q.chan[ch_idx]}, wb_dat_i, wb_sel_i)); // RULE2
      end
    end

    // fast clear: capture read or compare write clears the channel flag
    if (q.sc.fast_clr && ch_acc && req) begin
      if (wb_we_i == q.pc.ios[ch_idx]) begin
        clr_ch[ch_idx] = 1'b1; // RULE18
      end
    end
    if (q.sc.fast_clr && cnt_acc) begin
      clr_ovf = 1'b1; // RULE19
    end

    if (step && !cnt_written) begin
      d.cnt = cnt_inc; // RULE1
    end

    for (int i = 0; i < 8; i++) begin
      if (edge_ev[i]) begin
        d.chan[i] = q.cnt; // RULE2
      end
    end

    // set wins over clear
    d.flags = (q.flags & ~clr_ch) | hit | edge_ev;
    d.ovf = (q.ovf & ~clr_ovf) | ovf_set;

    d.lvl = lvl_next;
    for (int i = 0; i < 8; i++) begin
      d.pin_out[i] = own[i] ? lvl_next[i] : d.port[i]; // RULE4
    end
    d.pin_oe = own | q.ddr; // RULE3 RULE8
    d.pa_tick = e64; // RULE14

    d.rdat = 32'h0000_0000;
    if (rd) begin
      if (wb_adr_i == `TCC_OFF_DIR) begin
        d.rdat = {24'h0, q.pc.ios};
      end else if (wb_adr_i == `TCC_OFF_FORCE) begin
        d.rdat = 32'h0000_0000; // RULE6
      end else if (wb_adr_i == `TCC_OFF_MASK7) begin
        d.rdat = {24'h0, q.pc.mask};
      end else if (wb_adr_i == `TCC_OFF_DATA7) begin
        d.rdat = {24'h0, q.pc.data};
      end else if (wb_adr_i == `TCC_OFF_COUNT) begin
        // whole word sampled in one cycle, never torn
        d.rdat = {16'h0, q.cnt}; // RULE12
      end else if (wb_adr_i == `TCC_OFF_SYSCTL) begin
        d.rdat = {24'h0, q.sc, 4'h0};
      end else if (wb_adr_i == `TCC_OFF_ACTION) begin
        d.rdat = {16'h0, q.pc.act};
      end else if (wb_adr_i == `TCC_OFF_FLAGS) begin
        d.rdat = {23'h0, q.ovf, q.flags};
      end else if (wb_adr_i == `TCC_OFF_PORTDIR) begin
        d.rdat = {24'h0, q.ddr};
      end else if (wb_adr_i == `TCC_OFF_PORTDAT) begin
        d.rdat = {24'h0, (q.port & q.ddr) | (pin_i & ~q.ddr)};
      end else if (wb_adr_i == `TCC_OFF_PSEL) begin
        d.rdat = {29'h0, q.psel};
      end else if (ch_acc) begin
        d.rdat = {16'h0, q.chan[ch_idx]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0; // RULE21
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = (q.bus == TCC_BUS_ACK);
  assign wb_dat_o = q.rdat;
  assign pin_o = q.pin_out;
  assign pin_oe_o = q.pin_oe;
  assign pa_tick_o = q.pa_tick;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_force_read;
    rd && wb_adr_i == `TCC_OFF_FORCE;
  endsequence

  sequence s_answered_zero;
    wb_ack_o && wb_dat_o == 32'h0000_0000;
  endsequence

  sequence s_oc7_fire;
    hit[7] || force_w[7];
  endsequence

  AST_FORCE_READ_ZERO: assert property (s_force_read |=> s_answered_zero) // RULE6
    else $error("force register read returned nonzero");

  AST_HALT_DISABLED: assert property (!q.sc.en && !cnt_written |=> $stable(q.cnt) && !pa_tick_o) // RULE14
    else $error("counter moved while timer disabled");

  AST_HALT_WAIT: assert property (q.sc.stop_wait && wait_mode_i && !cnt_written |=> $stable(q.cnt)) // RULE15
    else $error("counter moved in wait with stop bit set");

  AST_HALT_DEBUG: assert property (q.sc.stop_dbg && debug_mode_i && !cnt_written |=> $stable(q.cnt)) // RULE16
    else $error("counter moved in debug with stop bit set");

  AST_CNT_WRITE_IGNORED: assert property (wr && wb_adr_i == `TCC_OFF_COUNT && !special_mode_i && !step
                                          |=> $stable(q.cnt)) // RULE11
    else $error("counter accepted a write outside special mode");

  AST_OVF_FAST_CLEAR: assert property (q.sc.fast_clr && cnt_acc && !ovf_set |=> !q.ovf) // RULE19
    else $error("counter access did not clear overflow flag");

  AST_FLAG_HOLD: assert property (!q.sc.fast_clr && !(wr && wb_adr_i == `TCC_OFF_FLAGS)
                                  |=> (q.flags & $past(q.flags)) == $past(q.flags)) // RULE17
    else $error("channel flag lost without a write-one clear");

  AST_FORCE_NO_FLAG: assert property (force_w[0] && !hit[0] && !edge_ev[0] && !q.flags[0]
                                      |=> !q.flags[0]) // RULE7
    else $error("forced action set the channel flag");

  AST_OC7_DATA: assert property (s_oc7_fire |=> (q.lvl & q.pc.mask) == (q.pc.data & q.pc.mask)) // RULE9 RULE10
    else $error("masked pins did not follow channel 7 data");

  AST_OWNED_PIN_OE: assert property (1'b1 |=> (pin_oe_o & $past(own)) == $past(own) &&
                                      (pin_o & $past(own)) == ($past(lvl_next) & $past(own))) // RULE3 RULE8
    else $error("owned pin not driven by timer level");

  AST_CAPTURE: assert property (edge_ev[0] |=> q.chan[0] == $past(q.cnt) && q.flags[0]) // RULE2
    else $error("capture did not latch the counter");

  AST_CNT_STEP: assert property (step && !cnt_written |=> q.cnt == $past(q.cnt) + 16'h0001) // RULE1
    else $error("counter did not advance on a prescaler step");

  AST_OVF_SET: assert property (ovf_set |=> q.ovf && q.cnt == 16'h0000) // RULE1
    else $error("wrap from all ones did not raise overflow");

  // a busy pin must not hide the written value from a later release
  AST_PORT_LATCH: assert property (wr && wb_adr_i == `TCC_OFF_PORTDAT && wb_sel_i[0]
                                   |=> q.port == $past(wb_dat_i[7:0])) // RULE4
    else $error("port write did not reach the latch");

  AST_RESET_ZERO: assert property (@(posedge clk_i) disable iff (1'b0)
                                   rst_i |=> q.pc.ios == 8'h00 && q.sc == 4'h0 && q.pc.mask == 8'h00) // RULE21
    else $error("control registers not zero after reset");

endmodule

`default_nettype wire

// ---- rtl/tcc_defs.svh ----
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// byte addresses on the register bus
`define TCC_OFF_DIR 8'h00
`define TCC_OFF_FORCE 8'h04
`define TCC_OFF_MASK7 8'h08
`define TCC_OFF_DATA7 8'h0C
`define TCC_OFF_COUNT 8'h10
`define TCC_OFF_SYSCTL 8'h14
`define TCC_OFF_ACTION 8'h18
`define TCC_OFF_FLAGS 8'h1C
`define TCC_OFF_PORTDIR 8'h40
`define TCC_OFF_PORTDAT 8'h44
`define TCC_OFF_PSEL 8'h48
// channel registers sit at 8'h20 + 4*n
`define TCC_CH_BLOCK 3'h1

// field positions
`define TCC_SC_EN_BIT 7
`define TCC_SC_WAIT_BIT 6
`define TCC_SC_DBG_BIT 5
`define TCC_SC_FFC_BIT 4
`define TCC_FLAG_OVF_BIT 8

// reset values and counts
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_CNT_MAX 16'hFFFF
`define TCC_PSEL_MAX 3'h5
`define TCC_PA_DIV_LAST 6'h3F

`endif

// ---- rtl/tcc_pkg.sv ----
package tcc_pkg;

  typedef enum logic [1:0] {
    TCC_ACT_OFF = 2'h0,
    TCC_ACT_TOGGLE = 2'h1,
    TCC_ACT_CLEAR = 2'h2,
    TCC_ACT_SET = 2'h3
  } tcc_action_type;

  typedef enum logic {
    TCC_BUS_IDLE = 1'b0,
    TCC_BUS_ACK = 1'b1
  } tcc_bus_type;

  typedef struct packed {
    logic en;
    logic stop_wait;
    logic stop_dbg;
    logic fast_clr;
  } tcc_sysctl_type;

  typedef struct packed {
    logic [7:0] ios;
    logic [15:0] act;
    logic [7:0] mask;
    logic [7:0] data;
  } tcc_pin_ctl_type;

  typedef struct packed {
    logic [5:0] div;
    logic [2:0] sel;
  } tcc_psc_type;

  typedef struct packed {
    tcc_bus_type bus;
    logic [31:0] rdat;
    tcc_pin_ctl_type pc;
    logic [7:0] flags;
    logic ovf;
    logic [7:0] ddr;
    logic [7:0] port;
    logic [7:0] lvl;
    logic [7:0] pin_prev;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [15:0] cnt;
    logic [7:0][15:0] chan;
    tcc_sysctl_type sc;
    logic [2:0] psel;
    logic pa_tick;
  } tcc_state_type;

endpackage

// ---- rtl/tcc_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.svh"

module tcc_prescaler
  import tcc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic step_o,
  output logic e64_o
);

  tcc_psc_type q;
  tcc_psc_type d;
  logic [5:0] m;

  function automatic logic [5:0] tcc_stage_mask(input logic [2:0] s);
    logic [2:0] c;
    c = (s > `TCC_PSEL_MAX) ? `TCC_PSEL_MAX : s;
    tcc_stage_mask = 6'((7'h01 << c) - 7'h01);
  endfunction

  assign m = tcc_stage_mask(q.sel);
  // counter steps once every 2^sel module clocks, sel above 5 counting as 5
  assign step_o = run_i & ((q.div & m) == m); // RULE1
  // divide-by-64 stops together with the timer
  assign e64_o = run_i & (q.div == `TCC_PA_DIV_LAST); // RULE14

  always_comb begin
    d = q;
    if (run_i) begin
      d.div = q.div + 6'h01;
    end
    // new factor only on a clean all-zero boundary
    if (q.div == 6'h00) begin
      d.sel = sel_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/tcc_pin_logic.sv ----
`timescale 1ns/1ns
`default_nettype none

module tcc_pin_logic
  import tcc_pkg::*;
(
  input wire tcc_pin_ctl_type ctl_i,
  input wire logic [7:0] hit_i,
  input wire logic [7:0] force_i,
  input wire logic [7:0] lvl_i,
  output logic [7:0] lvl_o,
  output logic [7:0] own_o
);

  logic oc7_fire;

  function automatic logic tcc_apply(input logic [1:0] a, input logic lv);
    case (tcc_action_type'(a))
      TCC_ACT_TOGGLE: tcc_apply = ~lv;
      TCC_ACT_CLEAR: tcc_apply = 1'b0;
      TCC_ACT_SET: tcc_apply = 1'b1;
      default: tcc_apply = lv;
    endcase
  endfunction

  // a forced action is the same event as a real match
  assign oc7_fire = hit_i[7] | force_i[7]; // RULE7

  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      logic fire;
      logic own_act;
      assign fire = hit_i[n] | force_i[n];
      assign own_act = ctl_i.act[2*n+1 -: 2] != 2'h0;
      // timer takes the pin over the direction setting
      assign own_o[n] = ctl_i.ios[n] & (own_act | ctl_i.mask[n]); // RULE3 RULE8
      always_comb begin
        lvl_o[n] = lvl_i[n];
        if (fire) begin
          lvl_o[n] = tcc_apply(ctl_i.act[2*n+1 -: 2], lvl_i[n]); // RULE20
        end
        // channel 7 data wins over a same-cycle lower action
        if (oc7_fire && ctl_i.mask[n]) begin
          lvl_o[n] = ctl_i.data[n]; // RULE9 RULE10
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- testbench/tcc_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module tcc_pin_model (
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_in_o
);
  // driven lines read back their own output value, the rest follow the far-side driver
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

`default_nettype wire

// ---- testbench/timer_capture_compare_control_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defs.svh"

module timer_capture_compare_control_tb;
  import tcc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic spec = 1'b0;
  logic wt = 1'b0;
  logic dbg = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0] ext = 8'h00;
  wire logic [31:0] rdat;
  wire logic ack;
  wire logic [7:0] pin_in;
  wire logic [7:0] pin_out;
  wire logic [7:0] pin_oe;
  wire logic pa;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  always #50 clk_i = ~clk_i;

  tcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .special_mode_i(spec), .wait_mode_i(wt), .debug_mode_i(dbg), .pin_i(pin_in),
    .pin_o(pin_out), .pin_oe_o(pin_oe), .pa_tick_o(pa));

  tcc_pin_model far (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_i(ext), .pin_in_o(pin_in));

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the rising edge that samples ack; data taken and request dropped at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    q = 32'h0;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic moving(input logic exp);
    logic [31:0] a;
    logic [31:0] b;
    bus(1'b0, `TCC_OFF_COUNT, 32'h0, a);
    bus(1'b0, `TCC_OFF_COUNT, 32'h0, b);
    chk({31'h0, a !== b}, {31'h0, exp});
  endtask

  task automatic pa_seen(input logic exp);
    int n;
    n = 0;
    repeat (200) begin
      @(negedge clk_i);
      if (pa === 1'b1) n++;
    end
    chk({31'h0, n > 0}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(`TCC_OFF_DIR, 32'h0);
    rdc(`TCC_OFF_MASK7, 32'h0);
    rdc(`TCC_OFF_DATA7, 32'h0);
    rdc(`TCC_OFF_COUNT, 32'h0);
    rdc(`TCC_OFF_SYSCTL, 32'h0);
    rdc(`TCC_OFF_FLAGS, 32'h0);
    rdc(8'h4C, 32'h0);
    wr(`TCC_OFF_DIR, 32'hA5);
    rdc(`TCC_OFF_DIR, 32'hA5);
    wr(`TCC_OFF_FORCE, 32'hFF);
    rdc(`TCC_OFF_FORCE, 32'h0);
    wr(`TCC_OFF_DIR, 32'h0);
  endtask

  task automatic t_force();
    logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic lv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(`TCC_OFF_DIR, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(`TCC_OFF_ACTION, {30'h0, acts[i]});
      wr(`TCC_OFF_FORCE, 32'h01);
      settle();
      chk({31'h0, pin_out[0]}, {31'h0, lv[i]});
      chk({31'h0, pin_oe[0]}, 32'h1);
      rdc(`TCC_OFF_FLAGS, 32'h0);
    end
    wr(`TCC_OFF_ACTION, 32'h0);
    wr(`TCC_OFF_DIR, 32'h0);
  endtask

  task automatic t_mask();
    wr(`TCC_OFF_DIR, 32'h82);
    wr(`TCC_OFF_MASK7, 32'h02);
    wr(`TCC_OFF_DATA7, 32'h02);
    rdc(`TCC_OFF_PORTDIR, 32'h0);
    chk({31'h0, pin_oe[1]}, 32'h1);
    wr(`TCC_OFF_FORCE, 32'h80);
    settle();
    chk({31'h0, pin_out[1]}, 32'h1);
    wr(`TCC_OFF_DATA7, 32'h0);
    wr(`TCC_OFF_ACTION, 32'h000C);
    wr(`TCC_OFF_FORCE, 32'h82);
    settle();
    chk({31'h0, pin_out[1]}, 32'h0);
    wr(`TCC_OFF_PORTDIR, 32'h02);
    wr(`TCC_OFF_PORTDAT, 32'h02);
    settle();
    chk({31'h0, pin_out[1]}, 32'h0);
    wr(`TCC_OFF_MASK7, 32'h0);
    wr(`TCC_OFF_ACTION, 32'h0);
    wr(`TCC_OFF_DIR, 32'h0);
    settle();
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
    wr(`TCC_OFF_PORTDIR, 32'h0);
  endtask

  task automatic t_count();
    wr(`TCC_OFF_COUNT, 32'h1234);
    rdc(`TCC_OFF_COUNT, 32'h0);
    spec <= 1'b1;
    wr(`TCC_OFF_COUNT, 32'h1234);
    rdc(`TCC_OFF_COUNT, 32'h1234);
    spec <= 1'b0;
    wr(`TCC_OFF_SYSCTL, 32'h80);
    moving(1'b1);
    wt <= 1'b1;
    wr(`TCC_OFF_SYSCTL, 32'hC0);
    moving(1'b0);
    wt <= 1'b0;
    moving(1'b1);
    dbg <= 1'b1;
    wr(`TCC_OFF_SYSCTL, 32'hA0);
    moving(1'b0);
    wr(`TCC_OFF_SYSCTL, 32'h80);
    moving(1'b1);
    pa_seen(1'b1);
    dbg <= 1'b0;
    wr(`TCC_OFF_SYSCTL, 32'h0);
    moving(1'b0);
    pa_seen(1'b0);
  endtask

  // enable and disable land three edges apart: FFFE steps through the wrap to 0001
  task automatic ovf(input logic [31:0] ffc);
    spec <= 1'b1;
    wr(`TCC_OFF_COUNT, 32'hFFFE);
    spec <= 1'b0;
    wr(`TCC_OFF_SYSCTL, 32'h80 | ffc);
    wr(`TCC_OFF_SYSCTL, ffc);
  endtask

  task automatic t_flags();
    ovf(32'h0);
    rdc(`TCC_OFF_FLAGS, 32'h100);
    rdc(`TCC_OFF_COUNT, 32'h1);
    rdc(`TCC_OFF_FLAGS, 32'h100);
    wr(`TCC_OFF_FLAGS, 32'h100);
    rdc(`TCC_OFF_FLAGS, 32'h0);
    ovf(32'h10);
    rdc(`TCC_OFF_COUNT, 32'h1);
    rdc(`TCC_OFF_FLAGS, 32'h0);
    wr(`TCC_OFF_SYSCTL, 32'h80);
    ext <= 8'h04;
    repeat (3) @(posedge clk_i);
    wr(`TCC_OFF_SYSCTL, 32'h10);
    rdc(`TCC_OFF_FLAGS, 32'h004);
    wr(8'h28, 32'h0);
    rdc(`TCC_OFF_FLAGS, 32'h004);
    rdc(8'h28, 32'h0);
    rdc(`TCC_OFF_FLAGS, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_force();
    t_mask();
    t_count();
    t_flags();
    stop_test();
  end
endmodule

`default_nettype wire
